// file: dv/sap_fifo_model.sv
// Transmit and receive FIFO model of the system side
`timescale 1ns/1ps
module sap_fifo_model #(
    parameter int RX_DEPTH = 4
) (
    // Clock
    input  wire logic        clk,
    // Transmit side
    output logic             tx_valid,
    output logic [31:0]      tx_data,
    input  wire logic        tx_pop,
    // Receive side
    output logic             rx_full,
    input  wire logic        rx_push,
    input  wire logic [31:0] rx_data
);
    logic [31:0] txq[$];
    logic [31:0] rxq[$];
    logic [31:0] last = 32'h00000000;
    initial begin
        tx_valid = 1'b0;
        tx_data = 32'hFFFFFFFF;
        rx_full = 1'b0;
    end
    // Empty FIFO shows the inverse of the last word, so stale data never looks fresh
    task refresh;
        tx_valid <= (txq.size() != 0);
        tx_data <= (txq.size() != 0) ? txq[0] : ~last;
        rx_full <= (rxq.size() >= RX_DEPTH);
    endtask : refresh
    task put(input logic [31:0] w);
        txq.push_back(w);
        refresh();
    endtask : put
    task drain;
        void'(rxq.pop_front());
        refresh();
    endtask : drain
    always @(posedge clk) begin
        if (tx_pop && txq.size() != 0)
            last = txq.pop_front();
        if (rx_push)
            rxq.push_back(rx_data);
        refresh();
    end
endmodule : sap_fifo_model

// file: dv/sap_shift_unit_assertions.sv
// Port assertions of the shift unit
`timescale 1ns/1ps
module sap_shift_unit_assertions (
    // Clock and reset
    input wire logic             clk,
    input wire logic             resetn,
    // APB
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pready,
    input wire logic             pslverr,
    // Machine side
    input wire logic             sm_cke,
    input wire logic             machine_restart_strobe,
    input wire sap_pkg::sap_op_t op,
    input wire logic             stall,
    input wire logic             out_valid,
    input wire logic [4:0]       side_pins,
    input wire logic             side_valid,
    // FIFO sides
    input wire logic             tx_valid,
    input wire logic             tx_pop,
    input wire logic             rx_full,
    input wire logic             rx_push
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    apb_answer_a: assert property (psel && !penable |=> pready) else $error("no pready after setup");
    apb_access_a: assert property (pready |-> psel && penable && !$past(pready)) else $error("stray pready");
    apb_err_a: assert property (pslverr |-> pready) else $error("pslverr outside access");
    side_set_a: assert property (sm_cke && op.side_en && !machine_restart_strobe
        |=> side_valid && side_pins == $past(op.side_val)) else $error("side-set lost");
    idle_hold_a: assert property (!sm_cke && !machine_restart_strobe
        |=> !out_valid && !rx_push && !tx_pop) else $error("activity without clock enable");
    out_cause_a: assert property (out_valid |-> $past(sm_cke) && $past(op.kind) == sap_pkg::SAP_OP_OUT && !stall)
        else $error("output without completed shift-out");
    push_cause_a: assert property (rx_push |-> $past(sm_cke) && !$past(rx_full)) else $error("push into full fifo");
    pop_fence_a: assert property (tx_pop |-> $past(tx_valid)) else $error("pop from empty fifo");
    restart_clr_a: assert property (machine_restart_strobe |=> !stall) else $error("stall kept over restart");
    stall_cov: cover property (stall && side_valid);
    push_cov: cover property (rx_push);
    refill_cov: cover property (out_valid && tx_pop);
endmodule : sap_shift_unit_assertions

bind sap_shift_unit sap_shift_unit_assertions sap_shift_unit_assertions_i (.clk, .resetn, .psel, .penable,
    .pready, .pslverr, .sm_cke, .machine_restart_strobe, .op, .stall, .out_valid, .side_pins, .side_valid,
    .tx_valid, .tx_pop, .rx_full, .rx_push);

// file: dv/sap_shift_unit_bench.sv
// Self-checking bench of the shift unit
`timescale 1ns/1ps
`include "sap_consts.svh"
module sap_shift_unit_bench;
    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h00000000;
    logic             sm_cke = 1'b0;
    logic             machine_restart_strobe = 1'b0;
    sap_pkg::sap_op_t op = '0;
    sap_pkg::sap_op_t o;
    logic [31:0]      prdata, out_data, tx_data, rx_data, rd, seen;
    logic [4:0]       side_pins;
    logic             pready, pslverr, stall, out_valid, side_valid, tx_valid, tx_pop, rx_full, rx_push, err;
    int               errors = 0;
    int               checks = 0;
    int               stalls;

    always #20 clk = ~clk;

    sap_shift_unit sap_shift_unit_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sm_cke(sm_cke), .machine_restart_strobe(machine_restart_strobe), .op(op), .stall(stall),
        .out_data(out_data), .out_valid(out_valid), .side_pins(side_pins), .side_valid(side_valid),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_pop(tx_pop), .rx_full(rx_full), .rx_push(rx_push),
        .rx_data(rx_data));
    sap_fifo_model sap_fifo_model_i (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_pop(tx_pop),
        .rx_full(rx_full), .rx_push(rx_push), .rx_data(rx_data));

    task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16)
            errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(what, rd, exp);
    endtask : rdchk

    function automatic logic [31:0] st(logic s, logic [5:0] i, logic [5:0] c);
        st = {15'h0000, s, 2'h0, i, 2'h0, c};
    endfunction : st

    function automatic sap_pkg::sap_op_t mk(sap_pkg::sap_op_e_t k, logic [4:0] n, logic [31:0] d);
        mk = '0;
        mk.kind = k;
        mk.bit_count = n;
        mk.data = d;
    endfunction : mk

    // Re-presents a stalled op, as the machine must
    task run(input sap_pkg::sap_op_t p, input int tries);
        stalls = 0;
        seen = 32'h00000000;
        repeat (tries) begin
            @(posedge clk);
            op <= p;
            sm_cke <= 1'b1;
            @(posedge clk);
            sm_cke <= 1'b0;
            #1;
            if (p.side_en)
                chk("side", {26'h0, side_valid, side_pins}, {26'h0, 1'b1, p.side_val});
            if (out_valid === 1'b1)
                seen = out_data;
            if (stall !== 1'b1)
                break;
            stalls++;
        end
        // The FIFO model acts on a pop or push one edge later; let it happen before callers look
        @(posedge clk);
        #1;
    endtask : run

    task restart;
        @(posedge clk);
        machine_restart_strobe <= 1'b1;
        @(posedge clk);
        machine_restart_strobe <= 1'b0;
    endtask : restart

    task t_regs;
        rdchk("ctrl reset", `SAP_ADDR_CTRL, 32'h00000000);
        rdchk("status reset", `SAP_ADDR_STATUS, st(1'b0, 6'h00, 6'h20));
        apb(1'b1, `SAP_ADDR_OSR, 32'hFFFFFFFF);
        rdchk("osr read only", `SAP_ADDR_OSR, 32'h00000000);
        apb(1'b0, 12'h010, 32'h00000000);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1'b1, `SAP_ADDR_CTRL, 32'h00003FFF);
        rdchk("ctrl rw", `SAP_ADDR_CTRL, 32'h00003FFF);
    endtask : t_regs

    // Manual counting, pull threshold 8 without autopull
    task t_counts;
        apb(1'b1, `SAP_ADDR_CTRL, 32'h00000020);
        run(mk(sap_pkg::SAP_OP_MOV_OSR, 5'h00, 32'h00001234), 1);
        rdchk("mov osr", `SAP_ADDR_STATUS, st(1'b0, 6'h00, 6'h00));
        sap_fifo_model_i.put(32'hC0DE0001);
        o = mk(sap_pkg::SAP_OP_PULL, 5'h00, 32'h00000000);
        o.cond = 1'b1;
        run(o, 1);
        chk("ifempty early", 32'(sap_fifo_model_i.txq.size()), 32'h1);
        run(mk(sap_pkg::SAP_OP_OUT, 5'h05, 32'h00000000), 1);
        run(mk(sap_pkg::SAP_OP_OUT, 5'h03, 32'h00000000), 1);
        rdchk("out count", `SAP_ADDR_STATUS, st(1'b0, 6'h00, 6'h08));
        run(o, 1);
        rdchk("ifempty pull", `SAP_ADDR_STATUS, st(1'b0, 6'h00, 6'h00));
        run(mk(sap_pkg::SAP_OP_OUT, 5'h1F, 32'h00000000), 1);
        run(mk(sap_pkg::SAP_OP_OUT, 5'h05, 32'h00000000), 1);
        run(mk(sap_pkg::SAP_OP_IN, 5'h07, 32'h00000055), 1);
        rdchk("in count", `SAP_ADDR_STATUS, st(1'b0, 6'h07, 6'h20));
        run(mk(sap_pkg::SAP_OP_IN, 5'h1F, 32'h00000055), 1);
        rdchk("in saturate", `SAP_ADDR_STATUS, st(1'b0, 6'h20, 6'h20));
        o = mk(sap_pkg::SAP_OP_OUT, 5'h09, 32'h00000000);
        o.to_isr = 1'b1;
        run(o, 1);
        rdchk("out to isr", `SAP_ADDR_STATUS, st(1'b0, 6'h09, 6'h20));
        run(mk(sap_pkg::SAP_OP_MOV_ISR, 5'h00, 32'h00000000), 1);
        rdchk("mov isr", `SAP_ADDR_STATUS, st(1'b0, 6'h00, 6'h20));
        run(mk(sap_pkg::SAP_OP_IN, 5'h03, 32'h00000005), 1);
        run(mk(sap_pkg::SAP_OP_PUSH, 5'h00, 32'h00000000), 1);
        rdchk("push", `SAP_ADDR_STATUS, st(1'b0, 6'h00, 6'h20));
        chk("push word", 32'(sap_fifo_model_i.rxq.size()), 32'h1);
        sap_fifo_model_i.drain();
        apb(1'b1, `SAP_ADDR_CTRL, 32'h00000000);
        run(mk(sap_pkg::SAP_OP_MOV_OSR, 5'h00, 32'h00000000), 1);
        restart();
        rdchk("restart", `SAP_ADDR_STATUS, st(1'b0, 6'h00, 6'h20));
    endtask : t_counts

    // Autopull with threshold field zero, meaning 32
    task t_autopull;
        apb(1'b1, `SAP_ADDR_CTRL, 32'h00000001);
        sap_fifo_model_i.put(32'hA5A50001);
        sap_fifo_model_i.put(32'hA5A50002);
        run(mk(sap_pkg::SAP_OP_OUT, 5'h00, 32'h00000000), 4);
        chk("load stall", 32'(stalls), 32'h1);
        chk("word one", seen, 32'hA5A50001);
        run(mk(sap_pkg::SAP_OP_OUT, 5'h00, 32'h00000000), 4);
        chk("refill no stall", 32'(stalls), 32'h0);
        chk("word two", seen, 32'hA5A50002);
        o = mk(sap_pkg::SAP_OP_OUT, 5'h00, 32'h00000000);
        o.side_en = 1'b1;
        o.side_val = 5'h15;
        run(o, 3);
        chk("fence", seen, 32'h00000000);
        sap_fifo_model_i.put(32'hA5A50003);
        repeat (3) @(posedge clk);
        rdchk("idle hold", `SAP_ADDR_STATUS, st(1'b1, 6'h00, 6'h20));
        // Restart while stalled, so the stall clear on restart is really exercised
        restart();
        run(mk(sap_pkg::SAP_OP_NONE, 5'h00, 32'h00000000), 1);
        rdchk("idle refill", `SAP_ADDR_STATUS, st(1'b0, 6'h00, 6'h00));
        sap_fifo_model_i.put(32'hA5A50004);
        o = mk(sap_pkg::SAP_OP_PULL, 5'h00, 32'h00000000);
        o.block = 1'b1;
        run(o, 2);
        chk("pull no-op", 32'(sap_fifo_model_i.txq.size()), 32'h1);
        run(mk(sap_pkg::SAP_OP_OUT, 5'h00, 32'h00000000), 4);
        chk("word three", seen, 32'hA5A50003);
    endtask : t_autopull

    // Autopush at 32 bits into a four-deep receive FIFO
    task t_autopush;
        restart();
        apb(1'b1, `SAP_ADDR_CTRL, 32'h00000002);
        for (int i = 0; i < 5; i++) begin
            run(mk(sap_pkg::SAP_OP_IN, 5'h00, 32'h5EED0000 + i), 2);
            chk("push stall", 32'(stalls), (i == 4) ? 32'h2 : 32'h0);
        end
        chk("first push", sap_fifo_model_i.rxq[0], 32'h5EED0000);
        sap_fifo_model_i.drain();
        run(mk(sap_pkg::SAP_OP_IN, 5'h00, 32'h5EED0004), 2);
        chk("late push", sap_fifo_model_i.rxq[3], 32'h5EED0004);
        rdchk("push clear", `SAP_ADDR_STATUS, st(1'b0, 6'h00, 6'h20));
    endtask : t_autopush

    task results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_counts();
        t_autopull();
        t_autopush();
        results();
    end

    // Whole run needs a few hundred cycles
    initial begin
        #(40 * 20000);
        errors++;
        results();
    end
endmodule : sap_shift_unit_bench

// file: rtl/sap_consts.svh
// Constants of the shift auto push and pull block
`ifndef SAP_CONSTS_SVH
`define SAP_CONSTS_SVH
`define SAP_WORD_W        32
`define SAP_CNT_W         6
`define SAP_CNT_FULL      6'h20
`define SAP_CNT_EMPTY     6'h00
`define SAP_ISR_CNT_RST   6'h00
`define SAP_OSR_CNT_RST   6'h20
`define SAP_THR_W         5
`define SAP_THR_ZERO      5'h00
`define SAP_ADDR_CTRL     12'h000
`define SAP_ADDR_STATUS   12'h004
`define SAP_ADDR_OSR      12'h008
`define SAP_ADDR_ISR      12'h00C
`define SAP_CTRL_PULL_EN  0
`define SAP_CTRL_PUSH_EN  1
`define SAP_CTRL_PULL_LO  2
`define SAP_CTRL_PULL_HI  6
`define SAP_CTRL_PUSH_LO  7
`define SAP_CTRL_PUSH_HI  11
`define SAP_CTRL_OUT_RGT  12
`define SAP_CTRL_IN_RGT   13
`define SAP_STAT_OSR_LO   0
`define SAP_STAT_OSR_HI   5
`define SAP_STAT_ISR_LO   8
`define SAP_STAT_ISR_HI   13
`define SAP_STAT_STALL    16
`define SAP_ZERO32        32'h00000000
`define SAP_SIDE_W        5
`endif

// file: rtl/sap_pkg.sv
// Types of the shift auto push and pull block
package sap_pkg;
    typedef enum logic [2:0] {
        SAP_OP_NONE,
        SAP_OP_OUT,
        SAP_OP_IN,
        SAP_OP_PULL,
        SAP_OP_PUSH,
        SAP_OP_MOV_OSR,
        SAP_OP_MOV_ISR
    } sap_op_e_t;

    typedef struct packed {
        sap_op_e_t   kind;
        logic [4:0]  bit_count;
        logic        cond;
        logic        block;
        logic        to_isr;
        logic [31:0] data;
        logic        side_en;
        logic [4:0]  side_val;
    } sap_op_t;

    typedef struct packed {
        logic        autopull;
        logic        autopush;
        logic [4:0]  pull_threshold_field;
        logic [4:0]  push_threshold_field;
        logic        out_right;
        logic        in_right;
    } sap_cfg_t;

    typedef struct packed {
        sap_cfg_t    cfg;
        logic [31:0] osr;
        logic [31:0] isr;
        logic [5:0]  osr_cnt;
        logic [5:0]  isr_cnt;
        logic        stall;
        logic [31:0] out_data;
        logic        out_valid;
        logic [4:0]  side_pins;
        logic        side_valid;
        logic        tx_pop;
        logic        rx_push;
        logic [31:0] rx_data;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sap_state_t;
endpackage : sap_pkg

// file: rtl/sap_shift_unit.sv
// Shift counters with automatic refill and drain of the shift registers
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "sap_consts.svh"
module sap_shift_unit (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Machine side
    input  wire logic             sm_cke,
    input  wire logic             machine_restart_strobe,
    input  wire sap_pkg::sap_op_t op,
    output logic                  stall,
    output logic      [31:0]      out_data,
    output logic                  out_valid,
    output logic      [4:0]       side_pins,
    output logic                  side_valid,
    // Transmit FIFO read side
    input  wire logic             tx_valid,
    input  wire logic [31:0]      tx_data,
    output logic                  tx_pop,
    // Receive FIFO write side
    input  wire logic             rx_full,
    output logic                  rx_push,
    output logic      [31:0]      rx_data
);
    sap_pkg::sap_state_t s;
    sap_pkg::sap_state_t next_s;

    logic       tx_ok;
    logic       rx_ok;
    logic [5:0] pull_thr;
    logic [5:0] push_thr;
    logic [5:0] nbits;
    logic [63:0] wide;
    logic [31:0] mask;
    logic [31:0] shifted_out;
    logic        apb_done;

    // Field value zero stands for a full word
    function automatic logic [5:0] thr_of(input logic [4:0] f);
        thr_of = (f == `SAP_THR_ZERO) ? `SAP_CNT_FULL : {1'b0, f};
    endfunction : thr_of

    function automatic logic [5:0] sat_add(input logic [5:0] a, input logic [5:0] b);
        logic [6:0] t;
        t = {1'b0, a} + {1'b0, b};
        sat_add = (t > {1'b0, `SAP_CNT_FULL}) ? `SAP_CNT_FULL : t[5:0];
    endfunction : sat_add

    always_comb begin
        next_s      = s;
        wide        = 64'h0000000000000000;
        shifted_out = `SAP_ZERO32;
        // A pop or push issued last cycle is not yet seen by the FIFO flags
        tx_ok       = tx_valid && !s.tx_pop;
        rx_ok       = !rx_full && !s.rx_push;
        pull_thr    = thr_of(s.cfg.pull_threshold_field);
        push_thr    = thr_of(s.cfg.push_threshold_field);
        nbits       = (op.bit_count == `SAP_THR_ZERO) ? `SAP_CNT_FULL : {1'b0, op.bit_count};
        wide        = 64'hFFFFFFFFFFFFFFFF << nbits;
        mask        = ~wide[31:0];
        apb_done    = psel && penable && s.pready;

        next_s.tx_pop     = 1'b0;
        next_s.rx_push    = 1'b0;
        next_s.out_valid  = 1'b0;
        next_s.side_valid = 1'b0;
        next_s.pready     = 1'b0;
        next_s.pslverr    = 1'b0;

        // APB: setup edge prepares the answer, the access completes one edge later
        if (psel && !penable) begin
            next_s.pready = 1'b1;
            case (paddr)
                `SAP_ADDR_CTRL: begin
                    next_s.prdata = `SAP_ZERO32;
                    next_s.prdata[`SAP_CTRL_PULL_EN] = s.cfg.autopull;
                    next_s.prdata[`SAP_CTRL_PUSH_EN] = s.cfg.autopush;
                    next_s.prdata[`SAP_CTRL_PULL_HI:`SAP_CTRL_PULL_LO] = s.cfg.pull_threshold_field;
                    next_s.prdata[`SAP_CTRL_PUSH_HI:`SAP_CTRL_PUSH_LO] = s.cfg.push_threshold_field;
                    next_s.prdata[`SAP_CTRL_OUT_RGT] = s.cfg.out_right;
                    next_s.prdata[`SAP_CTRL_IN_RGT]  = s.cfg.in_right;
                end
                `SAP_ADDR_STATUS: begin
                    next_s.prdata = `SAP_ZERO32;
                    next_s.prdata[`SAP_STAT_OSR_HI:`SAP_STAT_OSR_LO] = s.osr_cnt;
                    next_s.prdata[`SAP_STAT_ISR_HI:`SAP_STAT_ISR_LO] = s.isr_cnt;
                    next_s.prdata[`SAP_STAT_STALL] = s.stall;
                end
                `SAP_ADDR_OSR: begin
                    next_s.prdata = s.osr;
                end
                `SAP_ADDR_ISR: begin
                    next_s.prdata = s.isr;
                end
                default: begin
                    next_s.prdata  = `SAP_ZERO32;
                    next_s.pslverr = 1'b1;
                end
            endcase
        end else if (psel && penable && !s.pready) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = s.pslverr;
        end
        if (apb_done) begin
            next_s.pready = 1'b0;
            if (pwrite && paddr == `SAP_ADDR_CTRL) begin
                next_s.cfg.autopull = pwdata[`SAP_CTRL_PULL_EN];
                next_s.cfg.autopush = pwdata[`SAP_CTRL_PUSH_EN];
                next_s.cfg.pull_threshold_field = pwdata[`SAP_CTRL_PULL_HI:`SAP_CTRL_PULL_LO];
                next_s.cfg.push_threshold_field = pwdata[`SAP_CTRL_PUSH_HI:`SAP_CTRL_PUSH_LO];
                next_s.cfg.out_right = pwdata[`SAP_CTRL_OUT_RGT];
                next_s.cfg.in_right  = pwdata[`SAP_CTRL_IN_RGT];
            end
        end

        if (machine_restart_strobe) begin
            next_s.isr_cnt = `SAP_ISR_CNT_RST;
            next_s.osr_cnt = `SAP_OSR_CNT_RST;
            next_s.isr     = `SAP_ZERO32;
            next_s.stall   = 1'b0;
        end else if (sm_cke) begin
            if (op.side_en) begin
                next_s.side_pins  = op.side_val;
                next_s.side_valid = 1'b1;
            end
            case (op.kind)
                sap_pkg::SAP_OP_OUT: begin
                    if (s.cfg.autopull && s.osr_cnt >= pull_thr) begin
                        // Refill only; shifting the new word now would be too long a path
                        next_s.stall = 1'b1;
                        if (tx_ok) begin
                            next_s.osr     = tx_data;
                            next_s.osr_cnt = `SAP_CNT_EMPTY;
                            next_s.tx_pop  = 1'b1;
                        end
                    end else begin
                        next_s.stall = 1'b0;
                        if (s.cfg.out_right) begin
                            shifted_out = s.osr & mask;
                            wide        = {s.osr, `SAP_ZERO32} >> nbits;
                            next_s.osr  = wide[63:32];
                        end else begin
                            wide        = {`SAP_ZERO32, s.osr} << nbits;
                            shifted_out = wide[63:32];
                            next_s.osr  = wide[31:0];
                        end
                        next_s.osr_cnt = sat_add(s.osr_cnt, nbits);
                        if (op.to_isr) begin
                            next_s.isr     = shifted_out;
                            next_s.isr_cnt = nbits;
                        end else begin
                            next_s.out_data  = shifted_out;
                            next_s.out_valid = 1'b1;
                        end
                        if (s.cfg.autopull && next_s.osr_cnt >= pull_thr && tx_ok) begin
                            next_s.osr     = tx_data;
                            next_s.osr_cnt = `SAP_CNT_EMPTY;
                            next_s.tx_pop  = 1'b1;
                        end
                    end
                end
                sap_pkg::SAP_OP_IN: begin
                    if (s.cfg.in_right) begin
                        wide = {op.data, s.isr} >> nbits;
                    end else begin
                        wide = ({`SAP_ZERO32, s.isr} << nbits) | {`SAP_ZERO32, op.data & mask};
                    end
                    next_s.isr_cnt = sat_add(s.isr_cnt, nbits);
                    next_s.isr     = wide[31:0];
                    next_s.stall   = 1'b0;
                    if (s.cfg.autopush && next_s.isr_cnt >= push_thr) begin
                        if (!rx_ok) begin
                            // The shift is not committed; the machine repeats it
                            next_s.isr     = s.isr;
                            next_s.isr_cnt = s.isr_cnt;
                            next_s.stall   = 1'b1;
                        end else begin
                            next_s.rx_data = wide[31:0];
                            next_s.rx_push = 1'b1;
                            next_s.isr     = `SAP_ZERO32;
                            next_s.isr_cnt = `SAP_CNT_EMPTY;
                        end
                    end
                end
                sap_pkg::SAP_OP_PULL: begin
                    next_s.stall = 1'b0;
                    if ((op.cond || s.cfg.autopull) && s.osr_cnt < pull_thr) begin
                        next_s.stall = 1'b0;
                    end else if (tx_ok) begin
                        next_s.osr     = tx_data;
                        next_s.osr_cnt = `SAP_CNT_EMPTY;
                        next_s.tx_pop  = 1'b1;
                    end else if (op.block) begin
                        next_s.stall = 1'b1;
                    end
                end
                sap_pkg::SAP_OP_PUSH: begin
                    next_s.stall = 1'b0;
                    if (op.cond && s.isr_cnt < push_thr) begin
                        next_s.stall = 1'b0;
                    end else if (rx_ok) begin
                        next_s.rx_data = s.isr;
                        next_s.rx_push = 1'b1;
                        next_s.isr     = `SAP_ZERO32;
                        next_s.isr_cnt = `SAP_CNT_EMPTY;
                    end else if (op.block) begin
                        next_s.stall = 1'b1;
                    end
                end
                sap_pkg::SAP_OP_MOV_OSR: begin
                    next_s.stall   = 1'b0;
                    next_s.osr     = op.data;
                    next_s.osr_cnt = `SAP_CNT_EMPTY;
                end
                sap_pkg::SAP_OP_MOV_ISR: begin
                    next_s.stall   = 1'b0;
                    next_s.isr     = op.data;
                    next_s.isr_cnt = `SAP_CNT_EMPTY;
                end
                default: begin
                    next_s.stall = 1'b0;
                end
            endcase
            // Background refill between shift-outs; the OSR move and a PULL that popped above already cleared the count
            if (op.kind != sap_pkg::SAP_OP_OUT && s.cfg.autopull && !next_s.tx_pop
                && next_s.osr_cnt >= pull_thr && tx_ok) begin
                next_s.osr     = tx_data;
                next_s.osr_cnt = `SAP_CNT_EMPTY;
                next_s.tx_pop  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s         <= '0;
            s.osr_cnt <= `SAP_OSR_CNT_RST;
            s.isr_cnt <= `SAP_ISR_CNT_RST;
        end else begin
            s <= next_s;
        end
    end

    assign prdata     = s.prdata;
    assign pready     = s.pready;
    assign pslverr    = s.pslverr;
    assign stall      = s.stall;
    assign out_data   = s.out_data;
    assign out_valid  = s.out_valid;
    assign side_pins  = s.side_pins;
    assign side_valid = s.side_valid;
    assign tx_pop     = s.tx_pop;
    assign rx_push    = s.rx_push;
    assign rx_data    = s.rx_data;
endmodule : sap_shift_unit
